// File: rtl/strc_consts.svh
// constants for the serdes self-test and reset control block
// assumes inclusion by bare name from the top module
`ifndef STRC_CONSTS_SVH
`define STRC_CONSTS_SVH
// ==========================================
// management register offsets
`define STRC_REG_LOOPBACK    5'h16
`define STRC_REG_CONTROL6    5'h18
`define STRC_REG_SPARE1      5'h19
`define STRC_REG_STATUS0     5'h1a
`define STRC_REG_STATUS1     5'h1b
`define STRC_REG_STATUS2     5'h1c
`define STRC_REG_SOFT_RESET  5'h1d
`define STRC_REG_FACTORY     5'h1e
`define STRC_REG_RESULTS     5'h1f
// ==========================================
// field positions and reset values
`define STRC_VERIFY_BIT      9
`define STRC_GENERATE_BIT    8
`define STRC_FACTORY_RESET   16'h000b
`define STRC_FACTORY_WMASK   16'hff7f
`define STRC_PRBS_SEED       7'h7f
`define STRC_PASS_RUN        2'h3
// ==========================================
// frame and timing figures
`define STRC_PREAMBLE_BITS   6'h20
`define STRC_HDR_LAST        6'h0d
`define STRC_DATA_LAST       6'h0f
`define STRC_POR_TIME_US     1000
`define STRC_CLK_MHZ         100
`define STRC_PHY_ADDR        5'h00
`endif

// File: rtl/strc_pkg.sv
// types shared by the serdes self-test and reset control block
// assumes nothing of its surroundings; it includes no header
package strc_pkg;
  // ==========================================
  // management frame receiver states
  typedef enum logic [1:0] {
    STRC_PRE  = 2'b00,
    STRC_HDR  = 2'b01,
    STRC_TA   = 2'b10,
    STRC_DATA = 2'b11
  } strc_mgmt_st_t;
  typedef logic [9:0] strc_word_t;
endpackage : strc_pkg

// File: rtl/strc_top.sv
// serdes self-test and reset control: management slave, soft resets,
// loopback steering, pattern generators and checkers, power-on reset.
// assumes channel words are on ref_clk; mdc, mdio and pins are asynchronous.
// How it works
// R1: writing a receive soft-reset bit high resets that receive channel
// R2: writing a transmit soft-reset bit high resets that transmit channel
// R3: a soft-reset bit written one clears itself on the next management clock
// R4: transmit pairs share a bank, so a reset also blanks the partner
// R5: receive pass flags for all eight channels sit in the results high byte
// R6: transmit pass flags sit in the results low byte, factory use
// R7: serial loopback comes from the global pin or per-channel bits
// R8: looped channels hold their serial transmit output static
// R9: looped channels ignore their serial receive input
// R10: far-end bits steer received words back into the transmit path
// R11: far-end looped channels ignore parallel transmit data
// R12: far-end looped channels float their parallel receive outputs
// R13: during power-on reset receive data floats and receive clocks stay low
// R14: power-on reset lasts about one millisecond
// R15: each channel has a seven-bit pseudo-random generator and checker
// R16: pattern test is enabled by pin or by the generate bit
// R17: generator words replace the serializer input word
// R18: parallel transmit data is ignored while the pattern runs
// R19: the far side disregards receive data while the pattern pin is high
// R20: per-channel loopback bits are ored with the global loopback pin
// R21: the verify bit enables checking on all channels
// R22: the generate bit drives pattern to serial and parallel receive outputs
// R23: a receive pass flag reads one only while locked and error free
`timescale 1ns/10ps
`default_nettype none
`include "strc_consts.svh"
module strc_top
  import strc_pkg::*;
#(
  parameter int          CHANNELS   = 8,
  parameter int          POR_CYCLES = `STRC_POR_TIME_US * `STRC_CLK_MHZ,
  parameter logic [4:0]  PHY_ADDR   = `STRC_PHY_ADDR
) (
  input  wire logic                      ref_clk,
  input  wire logic                      rstn,
  input  wire logic                      mdc,
  input  wire logic                      mdio_in,
  output var  logic                      mdio_out,
  output var  logic                      mdio_oe_n,
  input  wire logic                      global_loopback_pin,
  input  wire logic                      pattern_enable_pin,
  input  wire logic [CHANNELS-1:0][9:0]  tx_parallel_in,
  input  wire logic [CHANNELS-1:0][9:0]  rx_serial_word,
  input  wire logic [CHANNELS-1:0]       rx_clk_in,
  output var  logic [CHANNELS-1:0][9:0]  tx_serial_word,
  output var  logic [CHANNELS-1:0][9:0]  rx_parallel_data,
  output var  logic [CHANNELS-1:0]       rx_parallel_oe_n,
  output var  logic [CHANNELS-1:0]       rx_clk_out,
  output var  logic                      por_active
);
  // ==========================================
  // helpers
  // ten serial steps of x^7+x^6+1, newest bit in the lsb
  function automatic strc_word_t prbs_word(input logic [6:0] s);
    logic [6:0] t;
    strc_word_t w;
    t = s;
    w = '0;
    for (int k = 0; k < 10; k++) begin
      w = {w[8:0], t[6] ^ t[5]};
      t = {t[5:0], t[6] ^ t[5]};
    end
    return w;
  endfunction : prbs_word

  // ==========================================
  // pin synchronisers
  logic [2:0]          mdc_s_q;
  logic [1:0]          mdio_s_q;
  logic [1:0]          global_loopback_pin_s_q;
  logic [1:0]          pat_s_q;
  logic [CHANNELS-1:0] rclk_s1_q;
  logic [CHANNELS-1:0] rclk_s2_q;
  logic                mdc_rise;
  logic                mdio_bit;
  // first stages feed only second stages; edge detect looks at stages two and three
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      mdc_s_q   <= 3'h0;
      mdio_s_q  <= 2'h3;
      global_loopback_pin_s_q  <= 2'h0;
      pat_s_q   <= 2'h0;
      rclk_s1_q <= '0;
      rclk_s2_q <= '0;
    end else begin
      mdc_s_q   <= {mdc_s_q[1:0], mdc};
      mdio_s_q  <= {mdio_s_q[0], mdio_in};
      global_loopback_pin_s_q  <= {global_loopback_pin_s_q[0], global_loopback_pin};
      pat_s_q   <= {pat_s_q[0], pattern_enable_pin};
      rclk_s1_q <= rx_clk_in;
      rclk_s2_q <= rclk_s1_q;
    end
  end
  assign mdc_rise = mdc_s_q[1] & ~mdc_s_q[2];
  assign mdio_bit = mdio_s_q[1];

  // ==========================================
  // power-on reset timer
  logic [31:0] por_cnt_q;
  logic        por_q;
  // length is a parameter so simulation can shorten the millisecond
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      por_cnt_q <= 32'h0;
      por_q     <= 1'b1;
    end else if (por_q) begin
      por_cnt_q <= por_cnt_q + 32'h1;
      por_q     <= (por_cnt_q + 32'h1) < 32'(POR_CYCLES);  // [R14]
    end
  end
  assign por_active = por_q;

  // ==========================================
  // management frame receiver
  strc_mgmt_st_t st_q;
  logic [5:0]    cnt_q;
  logic [13:0]   hdr_q;
  logic [15:0]   wdat_q;
  logic [15:0]   rd_q;
  logic          is_rd_q;
  logic [4:0]    addr_q;
  logic          wr_q;
  logic [15:0]   rd_val;
  logic [13:0]   hdr_full;
  assign hdr_full = {hdr_q[12:0], mdio_bit};
  // all moves happen a few ref_clk after mdc rises, giving the station a full period
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      st_q      <= STRC_PRE;
      cnt_q     <= 6'h0;
      hdr_q     <= 14'h0;
      wdat_q    <= 16'h0;
      rd_q      <= 16'h0;
      is_rd_q   <= 1'b0;
      addr_q    <= 5'h0;
      wr_q      <= 1'b0;
      mdio_out  <= 1'b1;
      mdio_oe_n <= 1'b1;
    end else begin
      wr_q <= 1'b0;
      if (mdc_rise) begin
        unique case (st_q)
          STRC_PRE: begin
            if (mdio_bit) begin
              cnt_q <= (cnt_q == `STRC_PREAMBLE_BITS) ? cnt_q : cnt_q + 6'h1;
            end else if (cnt_q == `STRC_PREAMBLE_BITS) begin
              st_q  <= STRC_HDR;
              hdr_q <= 14'h0;
              cnt_q <= 6'h1;
            end else begin
              cnt_q <= 6'h0;
            end
          end
          STRC_HDR: begin
            hdr_q <= hdr_full;
            cnt_q <= cnt_q + 6'h1;
            if (cnt_q == `STRC_HDR_LAST) begin
              cnt_q   <= 6'h0;
              addr_q  <= hdr_full[4:0];
              is_rd_q <= hdr_full[11:10] == 2'b10;
              rd_q    <= rd_val;
              if (hdr_full[13:12] == 2'b01 && hdr_full[9:5] == PHY_ADDR &&
                  (hdr_full[11:10] == 2'b10 || hdr_full[11:10] == 2'b01)) begin
                st_q <= STRC_TA;
              end else begin
                st_q <= STRC_PRE;
              end
            end
          end
          STRC_TA: begin
            cnt_q <= cnt_q + 6'h1;
            if (cnt_q == 6'h0 && is_rd_q) begin
              mdio_out  <= 1'b0;
              mdio_oe_n <= 1'b0;
            end
            if (cnt_q == 6'h1) begin
              st_q     <= STRC_DATA;
              cnt_q    <= 6'h0;
              mdio_out <= is_rd_q ? rd_q[15] : 1'b1;
              rd_q     <= {rd_q[14:0], 1'b0};
            end
          end
          STRC_DATA: begin
            cnt_q    <= cnt_q + 6'h1;
            wdat_q   <= {wdat_q[14:0], mdio_bit};
            mdio_out <= is_rd_q ? rd_q[15] : 1'b1;
            rd_q     <= {rd_q[14:0], 1'b0};
            if (cnt_q == `STRC_DATA_LAST) begin
              st_q      <= STRC_PRE;
              cnt_q     <= 6'h0;
              wr_q      <= ~is_rd_q;
              mdio_oe_n <= 1'b1;
              mdio_out  <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  // ==========================================
  // control registers
  logic [15:0] global_loopback_pin_q;
  logic [1:0]  pat_ctl_q;
  logic [15:0] srst_q;
  logic [15:0] fact_q;
  logic [CHANNELS-1:0] rx_pass_q;
  logic [CHANNELS-1:0] tx_pass_q;
  logic        wr_srst;
  // wdat_q already holds the last data bit when wr_q fires
  assign wr_srst = wr_q && addr_q == `STRC_REG_SOFT_RESET;
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      global_loopback_pin_q    <= 16'h0;
      pat_ctl_q <= 2'h0;
      fact_q    <= `STRC_FACTORY_RESET;
    end else if (wr_q) begin
      if (addr_q == `STRC_REG_LOOPBACK) global_loopback_pin_q <= wdat_q;
      if (addr_q == `STRC_REG_CONTROL6) begin
        pat_ctl_q <= wdat_q[`STRC_VERIFY_BIT:`STRC_GENERATE_BIT];
      end
      if (addr_q == `STRC_REG_FACTORY) fact_q <= wdat_q & `STRC_FACTORY_WMASK;
    end
  end
  // a write landing on the clearing edge wins, so a reset is never lost
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      srst_q <= 16'h0;
    end else if (wr_srst) begin
      srst_q <= wdat_q;                               // [R1] [R2]
    end else if (mdc_rise) begin
      srst_q <= 16'h0;                                // [R3]
    end
  end
  // read mux; reserved words and bits read as zero
  always_comb begin
    rd_val = 16'h0;
    unique case (hdr_full[4:0])
      `STRC_REG_LOOPBACK:   rd_val = global_loopback_pin_q;
      `STRC_REG_CONTROL6:   rd_val = {6'h0, pat_ctl_q, 8'h0};
      `STRC_REG_SOFT_RESET: rd_val = srst_q;
      `STRC_REG_FACTORY:    rd_val = fact_q;
      `STRC_REG_RESULTS:    rd_val = {rx_pass_q, tx_pass_q};  // [R5] [R6]
      default:              rd_val = 16'h0;
    endcase
  end

  // ==========================================
  // per-channel steering, generators and checkers
  logic                pat_on;
  logic                ver_en;
  logic [CHANNELS-1:0] global_loopback_pin_eff;
  logic [CHANNELS-1:0] fel;
  logic [CHANNELS-1:0] tx_hold;
  logic [CHANNELS-1:0] rx_rst;
  strc_word_t          gen_word [CHANNELS];
  strc_word_t          tx_src   [CHANNELS];
  strc_word_t          rx_src   [CHANNELS];
  logic [6:0]          gen_q    [CHANNELS];
  logic [6:0]          chk_q    [CHANNELS];
  logic [1:0]          run_q    [CHANNELS];
  assign pat_on = pat_s_q[1] | pat_ctl_q[0];          // [R16] [R22]
  assign ver_en = pat_ctl_q[1];                       // [R21]
  assign rx_rst = srst_q[15:8];
  for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
    assign global_loopback_pin_eff[i] = global_loopback_pin_q[8+i] | global_loopback_pin_s_q[1];   // [R7] [R20]
    assign fel[i]      = global_loopback_pin_q[i];
    // partner shares the clock and input bank, so it is blanked too
    assign tx_hold[i]  = srst_q[i] | srst_q[i^1];     // [R4]
    assign gen_word[i] = prbs_word(gen_q[i]);         // [R15]
    // far-end first, then pattern, else parallel input
    assign tx_src[i] = fel[i] ? rx_serial_word[i] :   // [R10] [R11]
                       pat_on ? gen_word[i] : tx_parallel_in[i];  // [R17] [R18]
    assign rx_src[i] = global_loopback_pin_eff[i] ? tx_src[i] : rx_serial_word[i];  // [R9]
    // generator restarts with its transmit reset
    always_ff @(posedge ref_clk) begin
      if (!rstn || srst_q[i]) begin
        gen_q[i] <= `STRC_PRBS_SEED;
      end else if (pat_on) begin
        gen_q[i] <= gen_word[i][6:0];
      end
    end
    // self-synchronising checker: every word reloads state from the line
    always_ff @(posedge ref_clk) begin
      if (!rstn || rx_rst[i] || !ver_en) begin
        chk_q[i]     <= `STRC_PRBS_SEED;
        run_q[i]     <= 2'h0;
        rx_pass_q[i] <= 1'b0;
      end else begin
        chk_q[i] <= rx_src[i][6:0];
        if (prbs_word(chk_q[i]) == rx_src[i]) begin
          run_q[i]     <= (run_q[i] == `STRC_PASS_RUN) ? run_q[i] : run_q[i] + 2'h1;
          rx_pass_q[i] <= run_q[i] == `STRC_PASS_RUN;  // [R23]
        end else begin
          run_q[i]     <= 2'h0;
          rx_pass_q[i] <= 1'b0;
        end
      end
    end
    // outputs
    always_ff @(posedge ref_clk) begin
      if (!rstn) begin
        tx_serial_word[i]   <= 10'h000;
        rx_parallel_data[i] <= 10'h000;
        rx_parallel_oe_n[i] <= 1'b1;
        rx_clk_out[i]       <= 1'b0;
        tx_pass_q[i]        <= 1'b0;
      end else begin
        tx_serial_word[i]   <= (global_loopback_pin_eff[i] || tx_hold[i]) ? 10'h000 : tx_src[i];  // [R8]
        rx_parallel_data[i] <= rx_rst[i] ? 10'h000 : (pat_on ? gen_word[i] : rx_src[i]);
        rx_parallel_oe_n[i] <= por_q | fel[i];        // [R12] [R13]
        rx_clk_out[i]       <= ~por_q & rclk_s2_q[i]; // [R13]
        tx_pass_q[i]        <= pat_on & ~tx_hold[i];
      end
    end
  end

  // ==========================================
  // checks
  AST_SRST_CLEAR: assert property (@(posedge ref_clk) disable iff (!rstn)  // [R3]
    srst_q != 16'h0 && mdc_rise && !wr_srst |=> srst_q == 16'h0)
    else $error("soft reset did not self clear");
  AST_RX_RST: assert property (@(posedge ref_clk) disable iff (!rstn)  // [R1]
    rx_rst[0] |=> !rx_pass_q[0] && rx_parallel_data[0] == 10'h000)
    else $error("receive reset did not clear channel");
  AST_TX_RST: assert property (@(posedge ref_clk) disable iff (!rstn)  // [R2]
    srst_q[0] |=> tx_serial_word[0] == 10'h000 && tx_serial_word[1] == 10'h000)
    else $error("transmit reset did not blank the pair");
  AST_GLOBAL_LOOPBACK_PIN_STATIC: assert property (@(posedge ref_clk) disable iff (!rstn)  // [R8]
    global_loopback_pin_s_q[1] |=> tx_serial_word == '0)
    else $error("serial output moved during loopback");
  AST_GLOBAL_LOOPBACK_PIN_RX: assert property (@(posedge ref_clk) disable iff (!rstn)  // [R9]
    global_loopback_pin_eff[0] && !pat_on && !rx_rst[0] |=> rx_parallel_data[0] == $past(tx_src[0]))
    else $error("loopback receive path wrong");
  AST_FEL_TX: assert property (@(posedge ref_clk) disable iff (!rstn)  // [R10]
    fel[0] && !global_loopback_pin_eff[0] && !tx_hold[0] |=> tx_serial_word[0] == $past(rx_serial_word[0]))
    else $error("far-end loop did not return receive word");
  AST_FEL_HIZ: assert property (@(posedge ref_clk) disable iff (!rstn)  // [R12]
    fel[0] |=> rx_parallel_oe_n[0])
    else $error("parallel receive driven during far-end loop");
  AST_POR: assert property (@(posedge ref_clk) disable iff (!rstn)  // [R13]
    por_q |=> rx_parallel_oe_n == '1 && rx_clk_out == '0)
    else $error("outputs active during power-on reset");
  AST_PAT_TX: assert property (@(posedge ref_clk) disable iff (!rstn)  // [R17]
    pat_on && !fel[0] && !global_loopback_pin_eff[0] && !tx_hold[0]
    |=> tx_serial_word[0] == $past(gen_word[0]))
    else $error("pattern not on serial output");
  AST_PASS_GATED: assert property (@(posedge ref_clk) disable iff (!rstn)  // [R23]
    rx_pass_q[0] |-> $past(ver_en, 1) && $past(run_q[0], 1) == `STRC_PASS_RUN)
    else $error("pass flag without lock");
endmodule : strc_top
`default_nettype wire

// File: rtl/strc_unused_placeholder_none.sv
// empty companion source: all of the block's logic sits in strc_top.sv
// assumes nothing of its surroundings; it declares no module
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// File: tb/strc_mdio_station.sv
// management station model: drives mdc and its side of the data line
// assumes ref_clk at 100 MHz; mdc half period is ten ref_clk cycles
`timescale 1ns/10ps
`default_nettype none
module strc_mdio_station (
  input  wire logic ref_clk,
  input  wire logic mdio_out,
  input  wire logic mdio_oe_n,
  output var  logic mdc,
  output var  logic mdio_in
);
  logic drv_en;
  logic drv_val;
  // ==========================================
  // wire level: device first, then station, else the pull-up
  always_comb mdio_in = !mdio_oe_n ? mdio_out : (drv_en ? drv_val : 1'b1);
  initial begin
    mdc = 1'b0;
    drv_en = 1'b0;
    drv_val = 1'b1;
  end
  // one bit: data set while mdc is low, line sampled just before the rise
  task automatic bit_cyc(input logic en, input logic v, output logic seen);
    drv_en = en;
    drv_val = v;
    repeat (10) @(negedge ref_clk);
    seen = mdio_in;
    mdc = 1'b1;
    repeat (10) @(negedge ref_clk);
    mdc = 1'b0;
  endtask : bit_cyc
  // whole frame; mdc stands still once it ends
  task automatic frame(input logic rd, input logic [4:0] ra, input logic [15:0] wd,
                       output logic [15:0] rdat);
    logic [63:0] f;
    logic        s;
    f = {32'hffffffff, 2'b01, rd ? 2'b10 : 2'b01, 5'h00, ra, 2'b10, wd};
    for (int i = 63; i >= 0; i--) begin
      bit_cyc(!(rd && i < 18), f[i], s);
      if (i < 16) begin
        rdat[i] = s;
      end
    end
    drv_en = 1'b0;
    repeat (10) @(negedge ref_clk);
  endtask : frame
endmodule : strc_mdio_station
`default_nettype wire

// File: tb/strc_top_tb_top.sv
// bench: reference datapath model and register checks for strc_top
// assumes the station model owns the management pins
`timescale 1ns/10ps
`default_nettype none
module strc_top_tb_top
  import strc_pkg::*;
;
  localparam int NCH = 8;
  logic                ref_clk, rstn, mdc, mdio_in, mdio_out, mdio_oe_n;
  logic                gl_lb, pat_pin, por_active, pat, chk_on;
  logic [NCH-1:0][9:0] tx_in, rx_ser, tx_out, rx_out, tx_prv, rx_prv, tx_po, rx_po;
  logic [NCH-1:0]      rx_ck_in, rx_ck_out, oe_n, lb_m, fe_m, txr_m, rxr_m, bad_m;
  logic [NCH-1:0]      ck_p1, ck_p2, ck_p3;  // recovered clock history, newest first
  logic [9:0]          src, e;
  int                  n_mismatch, samples_checked;
  // ==========================================
  // clock and instances
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  strc_top #(.POR_CYCLES(20)) strc_top_inst (.ref_clk(ref_clk), .rstn(rstn), .mdc(mdc),
    .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n),
    .global_loopback_pin(gl_lb), .pattern_enable_pin(pat_pin), .tx_parallel_in(tx_in),
    .rx_serial_word(rx_ser), .rx_clk_in(rx_ck_in), .tx_serial_word(tx_out),
    .rx_parallel_data(rx_out), .rx_parallel_oe_n(oe_n), .rx_clk_out(rx_ck_out),
    .por_active(por_active));
  strc_mdio_station strc_mdio_station_inst (.ref_clk(ref_clk), .mdio_out(mdio_out),
    .mdio_oe_n(mdio_oe_n), .mdc(mdc), .mdio_in(mdio_in));
  // ==========================================
  // helpers
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // next ten bits of x^7+x^6+1, newest at bit 0; zero state would lock up
  function automatic logic [9:0] prbs(input logic [6:0] st);
    logic [9:0] w;
    if (st == 7'h00) st = 7'h7f;
    for (int i = 9; i >= 0; i--) begin
      w[i] = st[6] ^ st[5];
      st = {st[5:0], w[i]};
    end
    return w;
  endfunction : prbs
  task automatic rdchk(input logic [4:0] a, input logic [15:0] x);
    logic [15:0] d;
    strc_mdio_station_inst.frame(1'b1, a, 16'h0000, d);
    chk("register", d, x);
  endtask : rdchk
  // write, let pins and syncs settle, then compare for n cycles
  task automatic apply(input logic [4:0] a, input logic [15:0] d, input int n);
    logic [15:0] x;
    chk_on = 1'b0;
    strc_mdio_station_inst.frame(1'b0, a, d, x);
    repeat (6) @(negedge ref_clk);
    chk_on = 1'b1;
    repeat (n) @(negedge ref_clk);
    chk_on = 1'b0;
  endtask : apply
  task automatic fin(input string t);
    $display("test %s done, %0d mismatches so far", t, n_mismatch);
  endtask : fin
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop
  // ==========================================
  // reference model one cycle behind the inputs, then fresh words
  always @(negedge ref_clk) begin
    if (chk_on) begin
      for (int c = 0; c < NCH; c++) begin
        src = fe_m[c] ? rx_prv[c] : (pat ? prbs(tx_po[c][6:0]) : tx_prv[c]);
        e = (gl_lb | lb_m[c] | txr_m[c] | txr_m[c^1]) ? 10'h000 : src;
        chk("tx word", 16'(tx_out[c]), 16'(e));
        e = rxr_m[c] ? 10'h000 : pat ? prbs(rx_po[c][6:0]) : (gl_lb | lb_m[c]) ? src : rx_prv[c];
        chk("rx word", 16'(rx_out[c]), 16'(e));
      end
      chk("rx drive", 16'(oe_n), 16'(fe_m));
      chk("rx clock", 16'(rx_ck_out), 16'(ck_p3));
    end
    tx_po = tx_out;
    rx_po = rx_out;
    for (int c = 0; c < NCH; c++) begin
      tx_in[c] = 10'($urandom);
      rx_ser[c] = bad_m[c] ? 10'($urandom) : prbs(rx_ser[c][6:0]);
    end
    // two sync stages plus the output flop: three cycles from pin to output
    ck_p3 = ck_p2;
    ck_p2 = ck_p1;
    rx_ck_in = 8'($urandom);
    ck_p1 = rx_ck_in;
    tx_prv = tx_in;
    rx_prv = rx_ser;
  end
  // hang guard, about two thirds again the expected run
  initial begin
    repeat (90000) @(posedge ref_clk);
    n_mismatch++;
    report_and_stop();
  end
  // ==========================================
  // main sequence
  initial begin
    void'($urandom(32'hbab2));
    rstn = 1'b0;
    {gl_lb, pat_pin, pat, chk_on} = 4'h0;
    {lb_m, fe_m, txr_m, rxr_m} = '0;
    bad_m = 8'hff;
    n_mismatch = 0;
    samples_checked = 0;
    tx_in = '0;
    rx_ser = '0;
    rx_ck_in = '0;
    repeat (20) @(negedge ref_clk);
    rstn = 1'b1;
    repeat (15) begin
      @(negedge ref_clk);
      chk("por flag", 16'(por_active), 16'h0001);
      chk("por pins", {oe_n, rx_ck_out}, 16'hff00);
    end
    repeat (10) @(negedge ref_clk);
    chk("por end", 16'(por_active), 16'h0000);
    fin("power-on");
    for (int a = 'h19; a <= 'h1f; a++) begin
      rdchk(5'(a), (a == 'h1e) ? 16'h000b : 16'h0000);
    end
    rdchk(5'h03, 16'h0000);
    apply(5'h19, 16'hffff, 1);
    apply(5'h1e, 16'hffff, 1);
    apply(5'h1f, 16'hffff, 1);
    rdchk(5'h19, 16'h0000);
    rdchk(5'h1e, 16'hff7f);
    rdchk(5'h1f, 16'h0000);
    fin("registers");
    lb_m = 8'h24;
    apply(5'h16, 16'h2400, 30);
    gl_lb = 1'b1;
    apply(5'h16, 16'h2400, 30);
    gl_lb = 1'b0;
    lb_m = 8'h00;
    fe_m = 8'h33;  // pairs a/b and e/f, so channel 0 is looped too
    apply(5'h16, 16'h0033, 30);
    fe_m = 8'h00;
    apply(5'h16, 16'h0000, 20);
    fin("loopback");
    // each bit stays set until the next mdc rise, and mdc stands still here
    for (int c = 0; c < NCH; c++) begin
      txr_m = 8'(1 << c);
      rxr_m = 8'(8'h80 >> c);
      apply(5'h1d, {rxr_m, txr_m}, 5);
      txr_m = 8'h00;
      rxr_m = 8'h00;
      rdchk(5'h1d, 16'h0000);
    end
    apply(5'h16, 16'h0000, 20);
    fin("soft reset");
    pat = 1'b1;
    apply(5'h18, 16'h0100, 30);
    pat_pin = 1'b1;  // receive bus now carries pattern, its data is not taken
    apply(5'h18, 16'h0000, 30);
    bad_m = 8'h08;
    apply(5'h18, 16'h0300, 40);
    rdchk(5'h1f, 16'hf7ff);
    bad_m = 8'hff;
    rdchk(5'h1f, 16'h00ff);
    pat_pin = 1'b0;
    pat = 1'b0;
    apply(5'h18, 16'h0000, 20);
    rdchk(5'h1f, 16'h0000);
    fin("pattern");
    report_and_stop();
  end
endmodule : strc_top_tb_top
`default_nettype wire
